// [logic/ref_mon_pkg.sv]
// Shared constants and types for the reference monitor and selector
package ref_mon_pkg;
    localparam int NUM_IN = 6;
    localparam int CLK_HZ = 25_000_000;
    localparam int WINDOW_MS = 128;
    localparam int WINDOW_CYC = WINDOW_MS * (CLK_HZ / 1000);
    localparam int DRIFT_PPM = 500;
    localparam int MISS_LIMIT = 2;
    localparam logic [3:0] SEL_AUTO = 4'h0;
    localparam logic [3:0] SEL_IN1 = 4'h3;
    localparam logic [3:0] SEL_IN4 = 4'h6;
    localparam logic [3:0] SEL_IN5 = 4'h9;
    localparam logic [3:0] SEL_IN6 = 4'hA;
    localparam logic [5:0] MASK_RESET = 6'h3F;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [2:0] NO_REF = 3'h0;

    // One leaky-bucket configuration set
    typedef struct packed {
        logic [7:0] size;
        logic [7:0] upper;
        logic [7:0] lower;
        logic [1:0] decay;
    } bucket_cfg_t;

    // Frequency monitor settings
    typedef struct packed {
        logic       use_loop_ref;
        logic [3:0] factor;
        logic [7:0] hard_thr;
        logic [7:0] soft_thr;
    } freq_cfg_t;

    // Per-input status carried out of the block
    typedef struct packed {
        logic       quiet_ref_alarm;
        logic       strict_offset_alarm;
        logic       lenient_offset_alarm;
        logic       valid_primary;
        logic       valid_secondary;
        logic [7:0] offset_value;
        logic [7:0] bucket_level;
    } ref_status_t;
endpackage

// [logic/input_ref_monitor_select.sv]
// Reference input quality monitor and loop reference selector
// Overview of operation
// - Each input has a leaky bucket evaluated every 128 ms window, plus one per event.
// - An event is an input drifting beyond 500 ppm of system clock in a window.
// - Bucket drops by one after each eventless decay interval of its configuration.
// - Four bucket sets of size, upper, lower and decay; each input picks one.
// - Bucket saturates at the configured size; further events there only restart its decay interval.
// - Quiet alarm rises above upper threshold, clears only below lower threshold.
// - An input with a quiet alarm is excluded from selection for both loops.
// - Frequency is compared against system clock or primary loop output, by config bit.
// - Accepting is (bits 7:4 plus one) times factor; rejecting uses bits 3:0.
// - Offset alarms set above rejecting, clear below accepting; soft likewise.
// - Strict alarm disqualifies selection; lenient alarm has no effect on it.
// - Each input reports an 8-bit offset value; times factor gives ppm.
// - Select code 0 is auto, 3 to 6 force inputs 1-4, 9-10 force 5-6.
// - Forced selection ignores all monitoring and validity results.
// - Auto selection takes the qualified input with highest priority rank.
// - Inputs join auto locking only with mask bit 0; all masked after reset.
// - Primary loop validity needs no quiet, strict or phase lock alarm, no LOS block, and, with rapid switching on, no two missed cycles.
// - Secondary loop validity needs no quiet, strict or LOS condition.
// - Any validity transition sets a sticky change flag and raises interrupt.
// - Loss of a loop's selected input sets a lost flag and raises interrupt.
`timescale 1ns/1ps
`default_nettype none

module input_ref_monitor_select #(
    parameter int NUM_IN = ref_mon_pkg::NUM_IN,
    parameter int WINDOW_CYC = ref_mon_pkg::WINDOW_CYC
) (
    input wire logic i_clk, // 25 MHz system clock
    input wire logic i_reset, // Asynchronous reset, active high
    input wire logic signed [15:0] i_offset_sys_ppm [NUM_IN], // Offset versus system clock
    input wire logic signed [15:0] i_offset_loop_ppm [NUM_IN], // Offset versus primary loop
    input wire ref_mon_pkg::bucket_cfg_t i_bucket_cfg [4], // Four bucket sets
    input wire logic [1:0] i_bucket_sel [NUM_IN], // Bucket set per input
    input wire ref_mon_pkg::freq_cfg_t i_freq_cfg, // Frequency monitor settings
    input wire logic [3:0] i_ref_rank [NUM_IN], // Priority, lower value wins
    input wire logic [3:0] i_loop_ref_choice_primary, // Primary loop select code
    input wire logic [3:0] i_loop_ref_choice_secondary, // Secondary loop select code
    input wire logic i_mask_wr, // Write strobe for participation mask
    input wire logic [NUM_IN-1:0] i_mask_data, // Participation mask, 0 joins
    input wire logic i_noise_window_wr, // Write strobe for noise window bit
    input wire logic i_noise_window_data, // Noise window bit value
    input wire logic [NUM_IN-1:0] i_phase_lock_fault, // Phase lock alarm per input
    input wire logic [NUM_IN-1:0] i_los_block, // Loss-of-signal disqualify per input
    input wire logic [NUM_IN-1:0] i_missed_two, // Two or more consecutive missed cycles
    input wire logic i_rapid_switch_enable, // Ultra-fast switching enable
    input wire logic [NUM_IN-1:0] i_change_clr, // Clear validity change flags
    input wire logic [1:0] i_lost_clr, // Clear selected-lost flags
    output var ref_mon_pkg::ref_status_t o_status [NUM_IN], // Per-input status
    output logic [NUM_IN-1:0] o_ref_participation_mask, // Participation mask
    output logic o_noise_window, // Noise window bit
    output logic [2:0] o_sel_primary, // Primary loop input, 0 none
    output logic [2:0] o_sel_secondary, // Secondary loop input, 0 none
    output logic [NUM_IN-1:0] o_validity_change_flag, // Sticky validity change
    output logic [1:0] o_selected_ref_lost_flag, // Sticky selected-lost per loop
    output logic o_irq // Any flag set
);
    localparam logic [7:0] ONE8 = 8'h01;

    // Absolute value of a signed offset
    function automatic logic [15:0] mag(input logic signed [15:0] v);
        mag = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // Threshold in ppm from a nibble and the factor
    function automatic logic [15:0] thr(input logic [3:0] nib, input logic [3:0] f);
        thr = 16'(({1'b0, nib} + 5'h01) * f);
    endfunction

    // Decode a select code into a forced input number, 0 when not forced
    function automatic logic [2:0] forced(input logic [3:0] code);
        if (code >= ref_mon_pkg::SEL_IN1 && code <= ref_mon_pkg::SEL_IN4) begin
            forced = 3'(code - ref_mon_pkg::SEL_IN1 + 4'h1);
        end else if (code == ref_mon_pkg::SEL_IN5 || code == ref_mon_pkg::SEL_IN6) begin
            forced = 3'(code - ref_mon_pkg::SEL_IN5 + 4'h5);
        end else begin
            forced = ref_mon_pkg::NO_REF;
        end
    endfunction

    // Best qualified input by rank, ties go to the lower input number
    function automatic logic [2:0] pick(input logic [NUM_IN-1:0] q,
                                        input logic [3:0] rk [NUM_IN]);
        logic [3:0] best;
        pick = ref_mon_pkg::NO_REF;
        best = 4'hF;
        for (int i = 0; i < NUM_IN; i++) begin
            if (q[i] && (pick == ref_mon_pkg::NO_REF || rk[i] < best)) begin
                pick = 3'(i + 1);
                best = rk[i];
            end
        end
    endfunction

    logic [31:0] win_cnt_r;
    logic win_end;
    logic [NUM_IN-1:0] drift_seen_r;
    logic [7:0] acc_r [NUM_IN];
    logic [3:0] quiet_win_r [NUM_IN];
    logic [NUM_IN-1:0] quiet_r, strict_r, lenient_r;
    logic [7:0] offset_val_r [NUM_IN];
    logic [NUM_IN-1:0] mask_r;
    logic noise_r;
    logic [NUM_IN-1:0] valid1, valid2, valid1_r, valid2_r;
    logic [NUM_IN-1:0] qual1, qual2;
    logic [2:0] sel1_r, sel2_r, sel1_nxt, sel2_nxt;
    logic [NUM_IN-1:0] chg_r;
    logic [1:0] lost_r, lost_set;

    // Observation window timer; window closes on the last cycle of the count
    assign win_end = (win_cnt_r == 32'(WINDOW_CYC - 1));
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            win_cnt_r <= 32'h0000_0000;
        end else begin
            win_cnt_r <= win_end ? 32'h0000_0000 : win_cnt_r + 32'h0000_0001;
        end
    end

    // Drift against the system clock latched until the window closes
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            drift_seen_r <= '0;
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (win_end) begin
                    drift_seen_r[i] <= 1'b0;
                end else if (mag(i_offset_sys_ppm[i]) > 16'(ref_mon_pkg::DRIFT_PPM)) begin
                    drift_seen_r[i] <= 1'b1;
                end
            end
        end
    end

    // Leaky buckets; a drift in the closing cycle still counts for that window
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < NUM_IN; i++) begin
                acc_r[i] <= ref_mon_pkg::ACC_RESET;
                quiet_win_r[i] <= 4'h0;
            end
        end else if (win_end) begin
            for (int i = 0; i < NUM_IN; i++) begin
                automatic ref_mon_pkg::bucket_cfg_t c = i_bucket_cfg[i_bucket_sel[i]];
                automatic logic ev = drift_seen_r[i] ||
                    (mag(i_offset_sys_ppm[i]) > 16'(ref_mon_pkg::DRIFT_PPM));
                // Decay interval is 1, 2, 4 or 8 eventless windows
                automatic logic [3:0] span = 4'h1 << c.decay;
                if (ev) begin
                    quiet_win_r[i] <= 4'h0;
                    if (acc_r[i] < c.size) begin
                        acc_r[i] <= acc_r[i] + ONE8;
                    end
                end else if (quiet_win_r[i] + 4'h1 >= span) begin
                    quiet_win_r[i] <= 4'h0;
                    if (acc_r[i] != 8'h00) begin
                        acc_r[i] <= acc_r[i] - ONE8;
                    end
                end else begin
                    quiet_win_r[i] <= quiet_win_r[i] + 4'h1;
                end
            end
        end
    end

    // Quiet alarm with hysteresis between the two bucket thresholds
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            quiet_r <= '0;
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                if (acc_r[i] > i_bucket_cfg[i_bucket_sel[i]].upper) begin
                    quiet_r[i] <= 1'b1;
                end else if (acc_r[i] < i_bucket_cfg[i_bucket_sel[i]].lower) begin
                    quiet_r[i] <= 1'b0;
                end
            end
        end
    end

    // Frequency alarms and reported offset; factor 0 parks the value at zero
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            strict_r <= '0;
            lenient_r <= '0;
            for (int i = 0; i < NUM_IN; i++) begin
                offset_val_r[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < NUM_IN; i++) begin
                automatic logic [3:0] f = i_freq_cfg.factor;
                automatic logic [15:0] m = mag(i_freq_cfg.use_loop_ref ?
                    i_offset_loop_ppm[i] : i_offset_sys_ppm[i]);
                automatic logic [15:0] q = (f == 4'h0) ? 16'h0000 : m / 16'(f);
                if (m > thr(i_freq_cfg.hard_thr[3:0], f)) begin
                    strict_r[i] <= 1'b1;
                end else if (m < thr(i_freq_cfg.hard_thr[7:4], f)) begin
                    strict_r[i] <= 1'b0;
                end
                if (m > thr(i_freq_cfg.soft_thr[3:0], f)) begin
                    lenient_r[i] <= 1'b1;
                end else if (m < thr(i_freq_cfg.soft_thr[7:4], f)) begin
                    lenient_r[i] <= 1'b0;
                end
                offset_val_r[i] <= (q > 16'h00FF) ? 8'hFF : q[7:0];
            end
        end
    end

    // Participation mask and noise window bit, both software settings
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            mask_r <= ref_mon_pkg::MASK_RESET;
            noise_r <= 1'b0;
        end else begin
            if (i_mask_wr) begin
                mask_r <= i_mask_data;
            end
            if (i_noise_window_wr) begin
                noise_r <= i_noise_window_data;
            end
        end
    end

    // Validity per loop; lenient alarm deliberately plays no part
    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            valid2[i] = !quiet_r[i] && !strict_r[i] && !i_los_block[i];
            valid1[i] = valid2[i] && !i_phase_lock_fault[i] &&
                !(i_rapid_switch_enable && i_missed_two[i]);
        end
        qual1 = valid1 & ~mask_r;
        qual2 = valid2 & ~mask_r;
    end

    // Selection: forced codes bypass monitoring, reserved codes select nothing
    always_comb begin
        sel1_nxt = forced(i_loop_ref_choice_primary);
        sel2_nxt = forced(i_loop_ref_choice_secondary);
        if (i_loop_ref_choice_primary == ref_mon_pkg::SEL_AUTO) begin
            sel1_nxt = pick(qual1, i_ref_rank);
        end
        if (i_loop_ref_choice_secondary == ref_mon_pkg::SEL_AUTO) begin
            sel2_nxt = pick(qual2, i_ref_rank);
        end
    end

    // Selected-lost detection uses last cycle's selection and validity
    always_comb begin
        lost_set[0] = (sel1_r != ref_mon_pkg::NO_REF) &&
            valid1_r[sel1_r - 3'h1] && !valid1[sel1_r - 3'h1];
        lost_set[1] = (sel2_r != ref_mon_pkg::NO_REF) &&
            valid2_r[sel2_r - 3'h1] && !valid2[sel2_r - 3'h1];
    end

    // Selection and validity history
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sel1_r <= ref_mon_pkg::NO_REF;
            sel2_r <= ref_mon_pkg::NO_REF;
            valid1_r <= '0;
            valid2_r <= '0;
        end else begin
            sel1_r <= sel1_nxt;
            sel2_r <= sel2_nxt;
            valid1_r <= valid1;
            valid2_r <= valid2;
        end
    end

    // Sticky flags; a new event wins over a clear in the same cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            chg_r <= '0;
            lost_r <= 2'h0;
        end else begin
            chg_r <= (chg_r & ~i_change_clr) |
                (valid1 ^ valid1_r) | (valid2 ^ valid2_r);
            lost_r <= (lost_r & ~i_lost_clr) | lost_set;
        end
    end

    // Outputs
    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            o_status[i].quiet_ref_alarm = quiet_r[i];
            o_status[i].strict_offset_alarm = strict_r[i];
            o_status[i].lenient_offset_alarm = lenient_r[i];
            o_status[i].valid_primary = valid1_r[i];
            o_status[i].valid_secondary = valid2_r[i];
            o_status[i].offset_value = offset_val_r[i];
            o_status[i].bucket_level = acc_r[i];
        end
    end
    assign o_ref_participation_mask = mask_r;
    assign o_noise_window = noise_r;
    assign o_sel_primary = sel1_r;
    assign o_sel_secondary = sel2_r;
    assign o_validity_change_flag = chg_r;
    assign o_selected_ref_lost_flag = lost_r;
    assign o_irq = (|chg_r) || (|lost_r);
endmodule

`default_nettype wire

// [tb/input_ref_monitor_select_monitor.sv]
// Port-level assertions for the reference monitor and selector
`timescale 1ns/1ps
`default_nettype none
module input_ref_monitor_select_monitor #(
    parameter int NUM_IN = ref_mon_pkg::NUM_IN,
    parameter int WINDOW_CYC = ref_mon_pkg::WINDOW_CYC
) (
    input wire logic i_clk, // Clock
    input wire logic i_reset, // Reset
    input wire logic signed [15:0] i_offset_sys_ppm [NUM_IN], // Offsets
    input wire logic signed [15:0] i_offset_loop_ppm [NUM_IN], // Offsets
    input wire ref_mon_pkg::bucket_cfg_t i_bucket_cfg [4], // Bucket sets
    input wire logic [1:0] i_bucket_sel [NUM_IN], // Set choice
    input wire ref_mon_pkg::freq_cfg_t i_freq_cfg, // Thresholds
    input wire logic [3:0] i_loop_ref_choice_primary, // Select code
    input wire logic [NUM_IN-1:0] i_phase_lock_fault, // Phase fault
    input wire logic [NUM_IN-1:0] i_los_block, // Signal loss
    input wire ref_mon_pkg::ref_status_t o_status [NUM_IN], // Status
    input wire logic [2:0] o_sel_primary, // Selection
    input wire logic [NUM_IN-1:0] o_validity_change_flag, // Flags
    input wire logic [1:0] o_selected_ref_lost_flag, // Flags
    input wire logic o_irq // Interrupt
);
    logic signed [15:0] m0;
    logic [15:0] mag0, rej0, acc0;
    ref_mon_pkg::ref_status_t s0;
    // Only input 1 is watched, which keeps the checker small
    assign m0 = i_freq_cfg.use_loop_ref ? i_offset_loop_ppm[0] : i_offset_sys_ppm[0];
    assign mag0 = m0[15] ? 16'(-m0) : 16'(m0);
    assign rej0 = (16'(i_freq_cfg.hard_thr[3:0]) + 16'h0001) * 16'(i_freq_cfg.factor);
    assign acc0 = (16'(i_freq_cfg.hard_thr[7:4]) + 16'h0001) * 16'(i_freq_cfg.factor);
    assign s0 = o_status[0];

    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    a_irq_flag_or: assert property (
        o_irq == ((|o_validity_change_flag) || (|o_selected_ref_lost_flag)))
        else $error("irq differs from flags");
    a_strict_set: assert property (mag0 > rej0 |=> s0.strict_offset_alarm)
        else $error("strict alarm not raised");
    a_strict_clear: assert property (mag0 < acc0 |=> !s0.strict_offset_alarm)
        else $error("strict alarm not cleared");
    a_forced_first: assert property (
        i_loop_ref_choice_primary == ref_mon_pkg::SEL_IN1 |=> o_sel_primary == 3'h1)
        else $error("forced selection wrong");
    a_reserved_none: assert property (
        i_loop_ref_choice_primary inside {4'h1, 4'h2, 4'h7, 4'h8, [4'hB:4'hF]}
        |=> o_sel_primary == ref_mon_pkg::NO_REF)
        else $error("reserved code selected an input");
    a_quiet_excl: assert property (
        s0.quiet_ref_alarm |=> !s0.valid_primary && !s0.valid_secondary)
        else $error("quiet input still valid");
    a_phase_primary: assert property (i_phase_lock_fault[0] |=> !s0.valid_primary)
        else $error("phase fault input valid");
    a_second_valid: assert property (
        !s0.quiet_ref_alarm && !s0.strict_offset_alarm && !i_los_block[0]
        |=> s0.valid_secondary)
        else $error("secondary validity missing");
    a_bucket_cap: assert property (
        s0.bucket_level <= i_bucket_cfg[i_bucket_sel[0]].size)
        else $error("bucket above size");
    a_change_flag: assert property (
        !$past(i_reset) && $changed(s0.valid_secondary) |-> ##[0:1] o_validity_change_flag[0])
        else $error("change flag not set");

    // Main scenarios reached
    c_strict: cover property ($rose(s0.strict_offset_alarm));
    c_quiet: cover property ($rose(s0.quiet_ref_alarm));
    c_lost: cover property ($rose(o_selected_ref_lost_flag[0]));
endmodule

bind input_ref_monitor_select input_ref_monitor_select_monitor #(
    .NUM_IN(NUM_IN),
    .WINDOW_CYC(WINDOW_CYC)
) u_monitor (
    .i_clk, .i_reset, .i_offset_sys_ppm, .i_offset_loop_ppm, .i_bucket_cfg, .i_bucket_sel,
    .i_freq_cfg, .i_loop_ref_choice_primary, .i_phase_lock_fault, .i_los_block, .o_status,
    .o_sel_primary, .o_validity_change_flag, .o_selected_ref_lost_flag, .o_irq
);
`default_nettype wire

// [tb/ref_partner.sv]
// Behavioural model of the six reference inputs and the primary loop output
`timescale 1ns/1ps
`default_nettype none
module ref_partner #(
    parameter logic signed [15:0] LOOP_SKEW = 16'sh001E // Loop output error, ppm
) (
    input wire logic signed [15:0] i_drift [6], // Drift of each reference
    output logic signed [15:0] o_offset_sys [6], // Seen against system clock
    output logic signed [15:0] o_offset_loop [6] // Seen against loop output
);
    // The loop output carries its own error, so the two views differ by a fixed skew
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            o_offset_sys[k] = i_drift[k];
            o_offset_loop[k] = i_drift[k] - LOOP_SKEW;
        end
    end
endmodule
`default_nettype wire

// [tb/input_ref_monitor_select_tb.sv]
// Self-checking bench for the reference monitor and selector
`timescale 1ns/1ps
`default_nettype none
module input_ref_monitor_select_tb;
    localparam int WIN = 16;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic signed [15:0] drift [6];
    logic signed [15:0] i_offset_sys_ppm [6];
    logic signed [15:0] i_offset_loop_ppm [6];
    ref_mon_pkg::bucket_cfg_t i_bucket_cfg [4];
    logic [1:0] i_bucket_sel [6];
    ref_mon_pkg::freq_cfg_t i_freq_cfg;
    logic [3:0] i_ref_rank [6];
    logic [3:0] i_loop_ref_choice_primary, i_loop_ref_choice_secondary;
    logic i_mask_wr, i_noise_window_wr, i_noise_window_data, i_rapid_switch_enable, o_irq;
    logic [5:0] i_mask_data, i_phase_lock_fault, i_los_block, i_missed_two, i_change_clr;
    logic [1:0] i_lost_clr, o_selected_ref_lost_flag;
    ref_mon_pkg::ref_status_t o_status [6];
    logic [5:0] o_ref_participation_mask, o_validity_change_flag;
    logic o_noise_window;
    logic [2:0] o_sel_primary, o_sel_secondary;
    int fail_count = 0;
    int cmp_count = 0;

    // 25 MHz system clock
    always #20 i_clk = ~i_clk;

    ref_partner u_refs (.i_drift(drift), .o_offset_sys(i_offset_sys_ppm),
        .o_offset_loop(i_offset_loop_ppm));
    input_ref_monitor_select #(.NUM_IN(6), .WINDOW_CYC(WIN)) DUT (
        .i_clk, .i_reset, .i_offset_sys_ppm, .i_offset_loop_ppm, .i_bucket_cfg, .i_bucket_sel,
        .i_freq_cfg, .i_ref_rank, .i_loop_ref_choice_primary, .i_loop_ref_choice_secondary,
        .i_mask_wr, .i_mask_data, .i_noise_window_wr, .i_noise_window_data,
        .i_phase_lock_fault, .i_los_block, .i_missed_two, .i_rapid_switch_enable,
        .i_change_clr, .i_lost_clr, .o_status, .o_ref_participation_mask, .o_noise_window,
        .o_sel_primary, .o_sel_secondary, .o_validity_change_flag, .o_selected_ref_lost_flag,
        .o_irq
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Bounded wait on input 1 bucket level; running out ends the run
    task automatic wait_bkt(input logic [7:0] lvl);
        for (int n = 0; o_status[0].bucket_level !== lvl; n++) begin
            if (n > 100) begin
                chk("bucket wait", lvl, o_status[0].bucket_level);
                give_verdict();
            end
            cyc(1);
        end
    endtask
    task automatic s_reset();
        chk("mask", 8'h3F, o_ref_participation_mask);
        chk("sel flags irq", 8'h00, {o_sel_primary, o_validity_change_flag[0], o_irq});
        chk("alarms bucket", 8'h00, o_status[0].bucket_level | o_status[0].quiet_ref_alarm);
        chk("noise", 8'h00, o_noise_window);
    endtask
    task automatic s_freq();
        drift[0] = 16'sh0019; // 25 ppm, above the 20 ppm rejecting level
        cyc(3);
        chk("strict", 8'h01, o_status[0].strict_offset_alarm);
        chk("offset", 8'h06, o_status[0].offset_value);
        drift[0] = -16'sh000C; // Inside the hysteresis band
        cyc(3);
        chk("strict hold", 8'h01, o_status[0].strict_offset_alarm);
        drift[0] = 16'sh0005;
        cyc(3);
        chk("strict clear", 8'h00, o_status[0].strict_offset_alarm);
        i_freq_cfg.use_loop_ref = 1'b1;
        cyc(3);
        chk("loop ref", 8'h01, o_status[0].strict_offset_alarm);
        i_freq_cfg.use_loop_ref = 1'b0;
        drift[0] = 16'sh0000;
        cyc(3);
    endtask
    task automatic s_auto();
        i_mask_wr = 1'b1;
        i_noise_window_wr = 1'b1;
        cyc(1);
        i_mask_wr = 1'b0;
        i_noise_window_wr = 1'b0;
        i_change_clr = 6'h3F;
        i_lost_clr = 2'h3;
        cyc(1);
        i_change_clr = 6'h00;
        i_lost_clr = 2'h0;
        cyc(3);
        chk("noise set", 8'h01, o_noise_window);
        chk("auto", 8'h24, {o_sel_primary, o_sel_secondary});
        chk("irq idle", 8'h00, o_irq);
        i_phase_lock_fault = 6'h09; // Input 1 faulted too, it is never the best rank
        cyc(4);
        chk("phase sel", 8'h34, {o_sel_primary, o_sel_secondary});
        chk("flags", 8'h05, {o_validity_change_flag[3], o_selected_ref_lost_flag});
        chk("irq", 8'h01, o_irq);
        i_phase_lock_fault = 6'h00;
        drift[3] = 16'sh000A; // Past the lenient level only
        cyc(4);
        chk("lenient", 8'h01, o_status[3].lenient_offset_alarm);
        chk("lenient sel", 8'h04, o_sel_primary);
        // Missed cycles only matter to the primary loop while fast switching is on
        i_rapid_switch_enable = 1'b1;
        i_missed_two = 6'h08;
        i_los_block = 6'h20;
        cyc(3);
        chk("los missed sel", 8'h14, {o_sel_primary, o_sel_secondary});
        {i_rapid_switch_enable, i_missed_two, i_los_block} = 13'h0000;
        drift[3] = 16'sh0019;
        i_mask_wr = 1'b1;
        i_mask_data = 6'h20;
        cyc(1);
        i_mask_wr = 1'b0;
        cyc(4);
        chk("strict mask sel", 8'h12, {o_sel_primary, o_sel_secondary});
        drift[3] = 16'sh0000;
        cyc(4);
    endtask
    task automatic s_forced();
        logic [2:0] exp;
        drift[0] = 16'sh0064; // Input 1 under strict alarm
        for (int c = 0; c < 16; c++) begin
            i_loop_ref_choice_primary = 4'(c);
            i_loop_ref_choice_secondary = 4'(c);
            exp = (c == 0) ? 3'h4 : (c >= 3 && c <= 6) ? 3'(c - 2) :
                (c == 9 || c == 10) ? 3'(c - 4) : 3'h0;
            cyc(2);
            chk("forced", {exp, 2'h0, exp}, {o_sel_primary, 2'h0, o_sel_secondary});
        end
        drift[0] = 16'sh0000;
    endtask
    task automatic s_bucket();
        drift[0] = 16'sh0258;
        drift[1] = 16'sh0258;
        cyc(6 * WIN);
        chk("bucket full", 8'h03, o_status[0].bucket_level);
        chk("bucket set1", 8'h02, o_status[1].bucket_level);
        chk("quiet", 8'h01, o_status[0].quiet_ref_alarm);
        drift[0] = 16'sh0000;
        drift[1] = 16'sh0000;
        wait_bkt(8'h02);
        cyc(WIN - 1);
        chk("decay hold", 8'h02, o_status[0].bucket_level);
        cyc(1);
        chk("decay step", 8'h01, o_status[0].bucket_level);
        cyc(2);
        chk("quiet hold", 8'h01, o_status[0].quiet_ref_alarm);
        wait_bkt(8'h00);
        cyc(2);
        chk("quiet clear", 8'h00, o_status[0].quiet_ref_alarm);
    endtask

    // Quiet configuration at time zero; loss and missed-cycle inputs idle outside selection
    initial begin
        drift = '{6{16'sh0000}};
        i_bucket_cfg = '{'{8'h03, 8'h01, 8'h01, 2'h0}, '{8'h02, 8'h01, 8'h01, 2'h0},
            '{8'hFF, 8'h80, 8'h40, 2'h3}, '{8'hFF, 8'h80, 8'h40, 2'h3}};
        i_bucket_sel = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
        i_freq_cfg = '{1'b0, 4'h4, 8'h14, 8'h01};
        i_ref_rank = '{4'h5, 4'h3, 4'h7, 4'h1, 4'h9, 4'h2};
        {i_loop_ref_choice_primary, i_loop_ref_choice_secondary} = 8'h00;
        {i_mask_wr, i_noise_window_wr, i_noise_window_data, i_rapid_switch_enable} = 4'h2;
        {i_mask_data, i_phase_lock_fault, i_los_block, i_missed_two, i_change_clr} = 30'h0;
        i_lost_clr = 2'h0;
        cyc(16);
        s_reset();
        i_reset = 1'b0;
        cyc(2);
        s_freq();
        s_auto();
        s_forced();
        s_bucket();
        give_verdict();
    end
endmodule
`default_nettype wire
